/* pkg/ewfc_pkg.sv */
package ewfc_pkg;
  localparam int unsigned NUM_SRC = 4;
  localparam int unsigned SRC_W   = 2;
  localparam int unsigned TYPE_W  = 8;
  // Header kinds the scheduler accepts
  typedef enum logic [0:0] {
    EWFC_HDR_SOURCE = 1'b0,
    EWFC_HDR_LINK   = 1'b1
  } ewfc_hdr_type;
  localparam logic [TYPE_W-1:0] TYPE_CTRL_MIN = 8'h01;
  localparam logic [TYPE_W-1:0] TYPE_CTRL_MAX = 8'h05;
  // Wake control field bit positions: request first, alert second
  localparam int unsigned WAKE_REQ_POS   = 1;
  localparam int unsigned NEW_ALERT_POS  = 0;
  localparam logic [1:0]  WAKE_RST       = 2'h0;
  localparam logic [1:0]  WAKE_FIRST_ON  = 2'h1;
  localparam logic [1:0]  WAKE_LAST_ON   = 2'h3;
  localparam logic [NUM_SRC-1:0] REQ_RST = '0;
endpackage

/* pkg/ewfc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ewfc_if;
  import ewfc_pkg::*;
  logic                 hdr_valid;
  logic [SRC_W-1:0]     hdr_src;
  ewfc_hdr_type         hdr_kind;
  logic [TYPE_W-1:0]    hdr_pkt_type;
  logic                 hdr_sig_present;
  logic [1:0]           hdr_wake_ctrl;
  modport source (output hdr_valid, hdr_src, hdr_kind, hdr_pkt_type,
                  hdr_sig_present, hdr_wake_ctrl);
  modport sched  (input  hdr_valid, hdr_src, hdr_kind, hdr_pkt_type,
                  hdr_sig_present, hdr_wake_ctrl);
endinterface
`default_nettype wire

/* core/ewfc_source.sv */
`timescale 1ns/100ps
`default_nettype none
module ewfc_source (
  input  wire logic                        clk_sys_i,
  input  wire logic                        nrst_i,
  ewfc_if.source                           bus,
  input  wire logic                        send_i,
  input  wire logic [ewfc_pkg::SRC_W-1:0]  src_id_i,
  input  wire ewfc_pkg::ewfc_hdr_type      kind_i,
  input  wire logic [ewfc_pkg::TYPE_W-1:0] pkt_type_i,
  input  wire logic              carries_alert_table_i,
  input  wire logic              wake_alert_active_i,
  input  wire logic              alert_newly_waking_i,
  output logic                   busy_o
);
  import ewfc_pkg::*;

  logic alert_flag;
  // Flag only a table whose version stepped with a newly waking alert
  assign alert_flag = carries_alert_table_i && alert_newly_waking_i;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bus.hdr_valid       <= 1'b0;
      bus.hdr_src         <= '0;
      bus.hdr_kind        <= EWFC_HDR_SOURCE;
      bus.hdr_pkt_type    <= '0;
      bus.hdr_sig_present <= 1'b0;
      bus.hdr_wake_ctrl   <= WAKE_RST;
      busy_o              <= 1'b0;
    end else begin
      bus.hdr_valid <= send_i;
      busy_o        <= send_i;
      if (send_i) begin
        bus.hdr_src         <= src_id_i;
        bus.hdr_kind        <= kind_i;
        bus.hdr_pkt_type    <= pkt_type_i;
        // Signaling present whenever a table type is named
        bus.hdr_sig_present <= (pkt_type_i != '0);
        // Request rides on every signaling packet, not only alerts
        bus.hdr_wake_ctrl[WAKE_REQ_POS]  <= wake_alert_active_i;
        bus.hdr_wake_ctrl[NEW_ALERT_POS] <= alert_flag;
      end
    end
  end
endmodule // ewfc_source
`default_nettype wire

/* core/ewfc_sched.sv */
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Two wake bits handled as one value
// - Field holds request flag then alert flag
// - Source flags request on every signaling packet
// - Alert flag only on alert table packets
// - Any source requesting gives non-zero value
// - Zero only when no source requests
// - Alert flag needs version step, new wake
// - New or updated waking alert sets flag
// - Alert flag with its request advances through 1,2,3
// - Single source sequence off, on, hold, step
// - Extra packets may update request anytime
// - Per-source requests kept, then merged
// - Source header valid only types 1-5
// - Link header valid only with signaling flag
module ewfc_sched (
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  ewfc_if.sched                        bus,
  output logic                         bootstrap_wake_bit_a_o,
  output logic                         bootstrap_wake_bit_b_o,
  output logic [ewfc_pkg::NUM_SRC-1:0] src_req_o
);
  import ewfc_pkg::*;

  // Fields of the header on the bus this cycle
  logic               hdr_valid;
  logic [SRC_W-1:0]   hdr_src;
  ewfc_hdr_type       hdr_kind;
  logic [TYPE_W-1:0]  hdr_pkt_type;
  logic               hdr_sig_present;
  logic               hdr_req;
  logic               hdr_alert;

  // Decode results
  logic               field_ok;
  logic               hdr_take;
  logic [NUM_SRC-1:0] src_sel;
  logic               alert_step;

  // Per-source request memory
  logic [NUM_SRC-1:0] req_q;
  logic [NUM_SRC-1:0] req_d;
  logic               any_req_d;

  // Merged emitted wake value
  logic [1:0]         wake_q;
  logic [1:0]         wake_d;

  // What the merged value does this cycle
  typedef enum logic [1:0] {
    ACT_HOLD,
    ACT_CLEAR,
    ACT_STEP,
    ACT_START
  } ewfc_wake_act_type;

  ewfc_wake_act_type  wake_act;

  // Wake field meaning depends on which tunnel the header came from
  function automatic logic field_usable(
    input ewfc_hdr_type      k,
    input logic [TYPE_W-1:0] t,
    input logic              sig
  );
    logic usable;
    if (k == EWFC_HDR_SOURCE) begin
      usable = (t >= TYPE_CTRL_MIN) && (t <= TYPE_CTRL_MAX);
    end else begin
      usable = sig;
    end
    return usable;
  endfunction

  // One-hot select of the source slot a header belongs to
  function automatic logic [NUM_SRC-1:0] src_onehot(
    input logic [SRC_W-1:0] s
  );
    logic [NUM_SRC-1:0] sel;
    sel = '0;
    for (int unsigned i = 0; i < NUM_SRC; i++) begin
      sel[i] = (s == SRC_W'(i));
    end
    return sel;
  endfunction

  // Next 'on' value; wraps 3 to 1 so an alert never emits zero
  function automatic logic [1:0] wake_advance(
    input logic [1:0] v
  );
    logic [1:0] nxt;
    if (v == WAKE_LAST_ON) begin
      nxt = WAKE_FIRST_ON;
    end else begin
      nxt = v + 2'h1;
    end
    return nxt;
  endfunction

  // True while any source still holds its request
  function automatic logic any_request(
    input logic [NUM_SRC-1:0] r
  );
    logic any;
    any = (r != '0);
    return any;
  endfunction

  // Field split: request first, alert second
  assign hdr_valid       = bus.hdr_valid;
  assign hdr_src         = bus.hdr_src;
  assign hdr_kind        = bus.hdr_kind;
  assign hdr_pkt_type    = bus.hdr_pkt_type;
  assign hdr_sig_present = bus.hdr_sig_present;
  assign hdr_req         = bus.hdr_wake_ctrl[WAKE_REQ_POS];
  assign hdr_alert       = bus.hdr_wake_ctrl[NEW_ALERT_POS];

  // Unusable headers are dropped without a trace
  assign field_ok = field_usable(hdr_kind, hdr_pkt_type, hdr_sig_present);
  assign hdr_take = hdr_valid && field_ok;
  assign src_sel  = src_onehot(hdr_src);

  // Alert without its own request cannot step the value
  assign alert_step = hdr_take && hdr_alert && hdr_req;

  // Only the addressed slot changes; other sources keep theirs
  always_comb begin
    req_d = req_q;
    for (int unsigned i = 0; i < NUM_SRC; i++) begin
      if (hdr_take && src_sel[i]) begin
        req_d[i] = hdr_req;
      end
    end
  end

  assign any_req_d = any_request(req_d);

  // Clear wins over step so a last withdrawn request always zeroes
  always_comb begin
    if (!any_req_d) begin
      wake_act = ACT_CLEAR;
    end else if (alert_step) begin
      wake_act = ACT_STEP;
    end else if (wake_q == WAKE_RST) begin
      wake_act = ACT_START;
    end else begin
      wake_act = ACT_HOLD;
    end
  end

  // A start caused by the header source's own request lands on one
  always_comb begin
    unique case (wake_act)
      ACT_CLEAR: begin
        wake_d = WAKE_RST;
      end
      ACT_STEP: begin
        wake_d = wake_advance(wake_q);
      end
      ACT_START: begin
        wake_d = WAKE_FIRST_ON;
      end
      ACT_HOLD: begin
        wake_d = wake_q;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      req_q <= REQ_RST;
    end else begin
      req_q <= req_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wake_q <= WAKE_RST;
    end else begin
      wake_q <= wake_d;
    end
  end

  // Both pins load from one value at one edge, never skewed
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bootstrap_wake_bit_a_o <= WAKE_RST[1];
      bootstrap_wake_bit_b_o <= WAKE_RST[0];
    end else begin
      bootstrap_wake_bit_a_o <= wake_d[1];
      bootstrap_wake_bit_b_o <= wake_d[0];
    end
  end

  // Request copy for status; loaded with the same next value
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      src_req_o <= REQ_RST;
    end else begin
      src_req_o <= req_d;
    end
  end

endmodule // ewfc_sched
`default_nettype wire

/* dv/ewfc_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module ewfc_sva
  import ewfc_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              nrst_i,
  input wire logic              hdr_valid,
  input wire logic [SRC_W-1:0]  hdr_src,
  input wire ewfc_hdr_type      hdr_kind,
  input wire logic [TYPE_W-1:0] hdr_pkt_type,
  input wire logic              hdr_sig_present,
  input wire logic [1:0]        hdr_wake_ctrl,
  input wire logic              bootstrap_wake_bit_a_o,
  input wire logic              bootstrap_wake_bit_b_o,
  input wire logic [NUM_SRC-1:0] src_req_o
);
  logic       acc;
  logic [1:0] w;
  assign w = {bootstrap_wake_bit_a_o, bootstrap_wake_bit_b_o};
  assign acc = hdr_valid && ((hdr_kind == EWFC_HDR_LINK) ? hdr_sig_present
               : (hdr_pkt_type inside {[TYPE_CTRL_MIN:TYPE_CTRL_MAX]}));
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wake_on_a: assert property (acc && hdr_wake_ctrl[1] && w == 2'h0 |=> w == 2'h1)
    else $error("wake did not start at one");
  req_on_a: assert property (acc && hdr_wake_ctrl[1] |=> w != 2'h0)
    else $error("wake zero while requested");
  step_up_a: assert property (
    acc && hdr_wake_ctrl == 2'h3 && w inside {2'h1, 2'h2}
    |=> w == $past(w) + 2'h1) else $error("wake step wrong");
  wrap_one_a: assert property (acc && hdr_wake_ctrl == 2'h3 && w == 2'h3 |=> w == 2'h1)
    else $error("wake did not wrap");
  hold_on_a: assert property (acc && hdr_wake_ctrl == 2'h2 && w != 2'h0 |=> $stable(w))
    else $error("wake moved without alert");
  refuse_a: assert property (!acc |=> $stable(w) && $stable(src_req_o))
    else $error("unusable header changed state");
  src_track_a: assert property (acc |=> src_req_o[$past(hdr_src)] == $past(hdr_wake_ctrl[1]))
    else $error("source request not kept");
  zero_merge_a: assert property ((src_req_o == '0) == (w == 2'h0))
    else $error("wake zero mismatch");
  cover property (acc && hdr_wake_ctrl == 2'h3 && w == 2'h3);
  cover property (hdr_valid && !acc);
  cover property (acc && !hdr_wake_ctrl[1] && w != 2'h0);
endmodule // ewfc_sva
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ewfc_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, send_i = 0, car_i = 0, act_i = 0, new_i = 0;
  logic [SRC_W-1:0]  src_i = '0;
  ewfc_hdr_type      kind_i = EWFC_HDR_SOURCE;
  logic [TYPE_W-1:0] typ_i = '0;
  logic a_o, b_o, busy;
  logic [NUM_SRC-1:0] req_o;
  int fail_count = 0, n_compared = 0, cyc = 0, mw = 0, mr = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  ewfc_if bus_if();
  ewfc_source ewfc_source_inst (.clk_sys_i, .nrst_i, .bus(bus_if), .send_i,
    .src_id_i(src_i), .kind_i, .pkt_type_i(typ_i), .carries_alert_table_i(car_i),
    .wake_alert_active_i(act_i), .alert_newly_waking_i(new_i), .busy_o(busy));
  ewfc_sched ewfc_sched_inst (.clk_sys_i, .nrst_i, .bus(bus_if),
    .bootstrap_wake_bit_a_o(a_o), .bootstrap_wake_bit_b_o(b_o), .src_req_o(req_o));
  ewfc_sva chk_inst (.clk_sys_i, .nrst_i, .hdr_valid(bus_if.hdr_valid),
    .hdr_src(bus_if.hdr_src), .hdr_kind(bus_if.hdr_kind),
    .hdr_pkt_type(bus_if.hdr_pkt_type), .hdr_sig_present(bus_if.hdr_sig_present),
    .hdr_wake_ctrl(bus_if.hdr_wake_ctrl), .bootstrap_wake_bit_a_o(a_o),
    .bootstrap_wake_bit_b_o(b_o), .src_req_o(req_o));
  task automatic cmp(input logic [NUM_SRC-1:0] got, input logic [NUM_SRC-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_wake(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t wake got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_busy(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t busy got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(44764));
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    cmp(req_o, 4'h0);
    repeat (400) begin
      @(posedge clk_sys_i);
      #1 src_i = SRC_W'($urandom);
      kind_i = ewfc_hdr_type'($urandom % 2);
      typ_i = TYPE_W'($urandom % 8);
      act_i = ($urandom % 4) != 0;
      car_i = (kind_i == EWFC_HDR_LINK || typ_i == 8'h04) && $urandom % 2;
      new_i = $urandom % 2;
      send_i = 1;
      @(posedge clk_sys_i);
      #1 send_i = 0;
      cmp_busy(busy, 1'b1);
      if ((kind_i == EWFC_HDR_LINK) ? (typ_i != 8'h00) : (typ_i inside {[1:5]})) begin
        mr[src_i] = act_i;
        if (mr == 0) mw = 0;
        else if (mw == 0) mw = 1;
        else if (act_i && car_i && new_i) mw = mw % 3 + 1;
      end
      repeat (2) @(posedge clk_sys_i);
      #1 cmp_wake({a_o, b_o}, 2'(mw));
      cmp(req_o, 4'(mr));
      cmp_busy(busy, 1'b0);
    end
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
